// file: hdl/aff_pkg.sv
// Notes on behaviour
// - Eight-bit fault byte, parameter fault in bit 0
// - Out-of-range process data sets parameter fault
// - Parameter fault blocks starting or continuing motion
// - Current above limit 8 ms sets overload
// - Overload needs enable cleared before new motion
// - Voltage fault: 10 s grace, new motion refused
// - Temperature fault: 10 s grace, new motion refused
// - Uncommanded tube movement sets backdrive flag
// - Bit 5 reports bus message timeout
// - Sleep after 5 s silence, safe-state wakes
package aff_pkg;

  // ----------------------------------------------------------------
  // Fault byte layout
  // ----------------------------------------------------------------
  localparam int          FAULT_W       = 8;
  localparam int          BIT_PARAM     = 0;
  localparam int          BIT_OVERLOAD  = 1;
  localparam int          BIT_VOLTAGE   = 2;
  localparam int          BIT_TEMP      = 3;
  localparam int          BIT_BACKDRIVE = 4;
  localparam int          BIT_TIMEOUT   = 5;
  localparam logic [7:0]  FAULT_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // Process data widths and default model ranges
  // ----------------------------------------------------------------
  localparam int          CUR_W         = 16;
  localparam int          POS_W         = 16;
  localparam int          SPD_W         = 8;
  localparam logic [15:0] CUR_MAX_DEF   = 16'hFFFF;
  localparam logic [15:0] POS_MAX_DEF   = 16'hFFFF;
  localparam logic [7:0]  SPD_MAX_DEF   = 8'hFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned OVL_TIME_MS   = 8;
  localparam int unsigned GRACE_TIME_S  = 10;
  localparam int unsigned SLEEP_TIME_S  = 5;
  localparam int unsigned OVL_CYC       = CLK_HZ / 1000 * OVL_TIME_MS;
  localparam int unsigned GRACE_CYC     = CLK_HZ * GRACE_TIME_S;
  localparam int unsigned SLEEP_CYC     = CLK_HZ * SLEEP_TIME_S;
  localparam int          TMR_W         = 32;

  // ----------------------------------------------------------------
  // Motion state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AFF_IDLE  = 3'h1,
    AFF_RUN   = 3'h2,
    AFF_SLEEP = 3'h4
  } aff_state_t;

endpackage : aff_pkg

// file: hdl/aff_tmr_if.sv
// Run request and expiry of one qualifying timer
interface aff_tmr_if;
  logic run;
  logic done;
  modport ctl (output run, input done);
  modport tmr (input run, output done);
endinterface : aff_tmr_if

// file: hdl/aff_timer.sv
// ------------------------------------------------------------------
// Qualifying timer: done after LIMIT consecutive cycles of run
// ------------------------------------------------------------------
module aff_timer #(
  parameter int unsigned LIMIT = 16,
  parameter int          WIDTH = aff_pkg::TMR_W
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  aff_tmr_if.tmr    tif
);
  import aff_pkg::*;

  localparam logic [WIDTH-1:0] LIM = WIDTH'(LIMIT);

  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;

  // Any gap in run restarts the window; saturate so done holds
  always_comb begin
    if (!tif.run) begin
      cnt_nxt = '0;
    end else if (cnt_r != LIM) begin
      cnt_nxt = cnt_r + 1'b1;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tif.done = (cnt_r == LIM);

endmodule : aff_timer

// file: hdl/aff_monitor.sv
// ------------------------------------------------------------------
// Actuator fault flag monitor
// ------------------------------------------------------------------
module aff_monitor #(
  parameter int unsigned         OVL_CYCLES   = aff_pkg::OVL_CYC,
  parameter int unsigned         GRACE_CYCLES = aff_pkg::GRACE_CYC,
  parameter int unsigned         SLEEP_CYCLES = aff_pkg::SLEEP_CYC,
  parameter logic [15:0]         CUR_MAX      = aff_pkg::CUR_MAX_DEF,
  parameter logic [15:0]         POS_MAX      = aff_pkg::POS_MAX_DEF,
  parameter logic [7:0]          SPD_MAX      = aff_pkg::SPD_MAX_DEF
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         clk_en,
  input  wire logic                         bus_activity,
  input  wire logic                         safe_state_msg,
  input  wire logic                         msg_timeout_evt,
  input  wire logic                         rpdo_valid,
  input  wire logic                         rpdo_motion_enable,
  input  wire logic [aff_pkg::CUR_W-1:0]    rpdo_current_limit,
  input  wire logic [aff_pkg::POS_W-1:0]    rpdo_position,
  input  wire logic [aff_pkg::SPD_W-1:0]    rpdo_speed,
  input  wire logic [aff_pkg::CUR_W-1:0]    motor_current,
  input  wire logic                         supply_ok,
  input  wire logic                         temp_ok,
  input  wire logic                         tube_moving,
  output logic                              motion_permit,
  output logic                              asleep,
  output logic [aff_pkg::FAULT_W-1:0]       fault_status_byte
);
  import aff_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  aff_state_t             state_r,     state_nxt;
  logic                   enable_r,    enable_nxt;
  logic [CUR_W-1:0]       cur_lim_r,   cur_lim_nxt;
  logic                   param_r,     param_nxt;
  logic                   ovl_r,       ovl_nxt;
  logic                   bd_r,        bd_nxt;
  logic                   tmo_r,       tmo_nxt;
  logic [FAULT_W-1:0]     fault_r,     fault_nxt;

  logic                   rx_take;
  logic                   rx_bad;
  logic                   env_bad;

  aff_tmr_if ovl_tif ();
  aff_tmr_if grace_tif ();
  aff_tmr_if sleep_tif ();

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  aff_timer #(.LIMIT(OVL_CYCLES)) u_ovl_tmr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .tif     (ovl_tif.tmr)
  );

  aff_timer #(.LIMIT(GRACE_CYCLES)) u_grace_tmr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .tif     (grace_tif.tmr)
  );

  aff_timer #(.LIMIT(SLEEP_CYCLES)) u_sleep_tmr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .tif     (sleep_tif.tmr)
  );

  // Qualifying conditions for each timer
  assign env_bad       = !supply_ok || !temp_ok;
  assign ovl_tif.run   = (state_r == AFF_RUN)
                         && (motor_current > cur_lim_r);
  // One grace window serves both supply and temperature faults
  assign grace_tif.run = (state_r == AFF_RUN) && env_bad;
  // Any bus frame restarts the silence count
  assign sleep_tif.run = (state_r != AFF_SLEEP) && !bus_activity;

  // Process data is ignored while asleep
  assign rx_take = rpdo_valid && (state_r != AFF_SLEEP);
  assign rx_bad  = (rpdo_current_limit > CUR_MAX)
                   || (rpdo_position > POS_MAX)
                   || (rpdo_speed > SPD_MAX);

  // ----------------------------------------------------------------
  // Command latch and fault flags
  // ----------------------------------------------------------------
  always_comb begin
    enable_nxt  = enable_r;
    cur_lim_nxt = cur_lim_r;
    param_nxt   = param_r;
    ovl_nxt     = ovl_r;
    bd_nxt      = bd_r;
    tmo_nxt     = tmo_r;
    if (rx_take) begin
      enable_nxt = rpdo_motion_enable;
      param_nxt  = rx_bad;
      if (!rx_bad) begin
        cur_lim_nxt = rpdo_current_limit;
      end
      // Overload is released only by a cleared enable
      if (!rpdo_motion_enable) begin
        ovl_nxt = 1'b0;
      end
      // A fresh frame acknowledges earlier backdrive and timeout
      bd_nxt  = 1'b0;
      tmo_nxt = 1'b0;
    end
    if (state_r == AFF_SLEEP && safe_state_msg) begin
      enable_nxt = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (ovl_tif.done) begin
      ovl_nxt = 1'b1;
    end
    if (tube_moving && state_r != AFF_RUN) begin
      bd_nxt = 1'b1;
    end
    if (msg_timeout_evt) begin
      tmo_nxt = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Motion state machine
  // ----------------------------------------------------------------
  always_comb begin
    case (state_r)
      AFF_IDLE: begin
        // New motion needs every blocking fault cleared
        if (sleep_tif.done) begin
          state_nxt = AFF_SLEEP;
        end else if (enable_r && !param_r && !ovl_r
                     && !env_bad) begin
          state_nxt = AFF_RUN;
        end else begin
          state_nxt = AFF_IDLE;
        end
      end
      AFF_RUN: begin
        if (sleep_tif.done) begin
          state_nxt = AFF_SLEEP;
        end else if (!enable_r || param_r || ovl_r) begin
          state_nxt = AFF_IDLE;
        end else if (grace_tif.done) begin
          state_nxt = AFF_IDLE;
        end else begin
          state_nxt = AFF_RUN;
        end
      end
      AFF_SLEEP: begin
        if (safe_state_msg) begin
          state_nxt = AFF_IDLE;
        end else begin
          state_nxt = AFF_SLEEP;
        end
      end
      default: begin
        state_nxt = AFF_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Fault byte assembly
  // ----------------------------------------------------------------
  always_comb begin
    fault_nxt                = FAULT_RESET;
    fault_nxt[BIT_PARAM]     = param_r;
    fault_nxt[BIT_OVERLOAD]  = ovl_r;
    fault_nxt[BIT_VOLTAGE]   = !supply_ok;
    fault_nxt[BIT_TEMP]      = !temp_ok;
    fault_nxt[BIT_BACKDRIVE] = bd_r;
    fault_nxt[BIT_TIMEOUT]   = tmo_r;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r   <= AFF_IDLE;
      enable_r  <= 1'b0;
      cur_lim_r <= '0;
      param_r   <= 1'b0;
      ovl_r     <= 1'b0;
      bd_r      <= 1'b0;
      tmo_r     <= 1'b0;
      fault_r   <= FAULT_RESET;
    end else if (clk_en) begin
      state_r   <= state_nxt;
      enable_r  <= enable_nxt;
      cur_lim_r <= cur_lim_nxt;
      param_r   <= param_nxt;
      ovl_r     <= ovl_nxt;
      bd_r      <= bd_nxt;
      tmo_r     <= tmo_nxt;
      fault_r   <= fault_nxt;
    end
  end

  // Outputs straight from state flops
  assign motion_permit     = (state_r == AFF_RUN);
  assign asleep            = (state_r == AFF_SLEEP);
  assign fault_status_byte = fault_r;

endmodule : aff_monitor

// file: verif/aff_assertions.sv
// ----
// Fault monitor port checks
// ----
module aff_assertions #(
  parameter int unsigned GRACE_CYCLES = 50
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic       msg_timeout_evt,
  input wire logic       rpdo_valid,
  input wire logic       rpdo_motion_enable,
  input wire logic       supply_ok,
  input wire logic       temp_ok,
  input wire logic       tube_moving,
  input wire logic       motion_permit,
  input wire logic       asleep,
  input wire logic [7:0] fault_status_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  import aff_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [31:0] grace_cnt_r;
  logic [31:0] grace_cnt_nxt;
  // Run time under a bad environment; restarts when it recovers
  always_comb begin
    grace_cnt_nxt = grace_cnt_r;
    if (!motion_permit || (supply_ok && temp_ok))
      grace_cnt_nxt = '0;
    else if (clk_en)
      grace_cnt_nxt = grace_cnt_r + 1;
  end
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) grace_cnt_r <= '0;
    else grace_cnt_r <= grace_cnt_nxt;
  a_high_bits_zero: assert property (fault_status_byte[7:6] == 2'h0)
    else $error("upper fault bits set");
  a_param_blocks_run: assert property (fault_status_byte[0] &&
    $past(fault_status_byte[0]) |-> !motion_permit)
    else $error("motion with parameter fault");
  a_enable_low_stop: assert property (rpdo_valid &&
    !rpdo_motion_enable && clk_en && !asleep ##1 clk_en |=> !motion_permit)
    else $error("motion after disable frame");
  a_volt_follow: assert property (clk_en |=>
    fault_status_byte[2] == !$past(supply_ok))
    else $error("voltage bit wrong");
  a_temp_follow: assert property (clk_en |=>
    fault_status_byte[3] == !$past(temp_ok))
    else $error("temperature bit wrong");
  a_env_no_start: assert property (!motion_permit &&
    (fault_status_byte[2] && !supply_ok || fault_status_byte[3] && !temp_ok)
    |=> !motion_permit)
    else $error("motion started in bad environment");
  a_grace_bound: assert property (grace_cnt_r <= GRACE_CYCLES + 3)
    else $error("grace period overrun");
  a_backdrive_set: assert property (tube_moving && !motion_permit &&
    clk_en ##1 clk_en |=> fault_status_byte[4])
    else $error("backdrive not flagged");
  a_timeout_set: assert property (msg_timeout_evt && clk_en ##1 clk_en
    |=> fault_status_byte[5])
    else $error("timeout not flagged");
  a_sleep_no_run: assert property (asleep |-> !motion_permit)
    else $error("motion while asleep");
endmodule : aff_assertions

bind aff_monitor aff_assertions #(.GRACE_CYCLES(GRACE_CYCLES))
  aff_assertions_inst (.ref_clk, .rst, .clk_en, .msg_timeout_evt,
  .rpdo_valid, .rpdo_motion_enable, .supply_ok, .temp_ok, .tube_moving,
  .motion_permit, .asleep, .fault_status_byte);

// file: verif/aff_master_model.sv
// ----
// Bus master issuing process data frames
// ----
module aff_master_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        send,
  input  wire logic        en,
  input  wire logic [15:0] cur,
  input  wire logic [15:0] pos,
  input  wire logic [7:0]  spd,
  output logic             rpdo_valid,
  output logic             rpdo_motion_enable,
  output logic [15:0]      rpdo_current_limit,
  output logic [15:0]      rpdo_position,
  output logic [7:0]       rpdo_speed,
  output logic             bus_activity
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [40:0] fld_r;
  // One-cycle frame; fields scramble between frames so stale data shows
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rpdo_valid <= 1'b0;
      fld_r <= '0;
    end else begin
      rpdo_valid <= send;
      fld_r <= send ? {en, cur, pos, spd} : ~fld_r;
    end
  end
  assign {rpdo_motion_enable, rpdo_current_limit} = fld_r[40:24];
  assign {rpdo_position, rpdo_speed} = fld_r[23:0];
  assign bus_activity = rpdo_valid; // Frames keep the link awake
endmodule : aff_master_model

// file: verif/aff_monitor_tb.sv
// ----
// Fault monitor bench
// ----
module aff_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import aff_pkg::*;
  logic ref_clk = 0, rst = 1, clk_en = 1, send = 0, en = 0, chk = 0;
  logic safe_state_msg = 0, msg_timeout_evt = 0, tube_moving = 0;
  logic supply_ok = 1, temp_ok = 1;
  logic [15:0] cur = '0, pos = '0, motor_current = '0, p0;
  logic [7:0] spd = '0;
  logic rpdo_valid, rpdo_motion_enable, bus_activity, motion_permit, asleep;
  logic [15:0] rpdo_current_limit, rpdo_position;
  logic [7:0] rpdo_speed, fault_status_byte;
  logic [9:0] exp_q[$];
  wire logic [9:0] seen = {motion_permit, asleep, fault_status_byte};
  int num_errors = 0, samples_checked = 0, seed = 49;
  always #10 ref_clk = ~ref_clk;
  aff_master_model aff_master_model_inst (.ref_clk, .rst, .send, .en, .cur,
    .pos, .spd, .rpdo_valid, .rpdo_motion_enable, .rpdo_current_limit,
    .rpdo_position, .rpdo_speed, .bus_activity);
  aff_monitor #(.OVL_CYCLES(20), .GRACE_CYCLES(50), .SLEEP_CYCLES(100),
    .CUR_MAX(16'h0FFF), .POS_MAX(16'h0FFF), .SPD_MAX(8'h7F))
    aff_monitor_inst (.ref_clk, .rst, .clk_en, .bus_activity,
    .safe_state_msg, .msg_timeout_evt, .rpdo_valid, .rpdo_motion_enable,
    .rpdo_current_limit, .rpdo_position, .rpdo_speed, .motor_current,
    .supply_ok, .temp_ok, .tube_moving, .motion_permit, .asleep,
    .fault_status_byte);
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t status %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic frame(input logic e, input logic [15:0] c,
                       input logic [15:0] p, input logic [7:0] s);
    @(posedge ref_clk);
    send <= 1'b1;
    en <= e;
    cur <= c;
    pos <= p;
    spd <= s;
    @(posedge ref_clk);
    send <= 1'b0;
  endtask : frame
  // Expected {permit, asleep, fault byte} queued for the watcher
  task automatic note(input int w, input logic [9:0] exp);
    repeat (w) @(posedge ref_clk);
    exp_q.push_back(exp);
    chk <= 1'b1;
    @(posedge ref_clk);
    chk <= 1'b0;
  endtask : note
  // Falling-edge sample keeps clear of the flop updates
  always @(negedge ref_clk)
    if (chk) check(seen, exp_q.pop_front());
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin : main
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    note(1, 10'h000);
    p0 = 16'($random(seed)) & 16'h0FFF;
    frame(1'b1, 16'h0100, p0, 8'h10);
    note(4, 10'h200);
    motor_current <= 16'h0200;
    note(15, 10'h200);
    note(15, 10'h002);
    motor_current <= 16'($random(seed)) & 16'h00FF;
    frame(1'b1, 16'h0100, p0, 8'h10);
    note(4, 10'h002);
    frame(1'b0, 16'h0100, p0, 8'h10);
    note(4, 10'h000);
    frame(1'b1, 16'h0100, p0, 8'h10);
    note(4, 10'h200);
    $display("overload test done");
    // Each field out of range once, then limits exactly at the maximum
    for (int i = 0; i < 3; i++) begin
      frame(1'b1, (i == 0) ? 16'hF000 : 16'h0100,
            (i == 1) ? 16'hF000 : p0, (i == 2) ? 8'hF0 : 8'h10);
      note(4, 10'h001);
      frame(1'b1, 16'h0FFF, 16'h0FFF, 8'h7F);
      note(4, 10'h200);
    end
    $display("range test done");
    for (int j = 0; j < 2; j++) begin
      supply_ok <= (j != 0);
      temp_ok <= (j == 0);
      note(10, 10'h200 | (10'h004 << j));
      note(50, 10'h004 << j);
      frame(1'b1, 16'h0100, p0, 8'h10);
      note(4, 10'h004 << j);
      supply_ok <= 1'b1;
      temp_ok <= 1'b1;
      note(4, 10'h200);
    end
    $display("environment test done");
    frame(1'b0, 16'h0100, p0, 8'h10);
    repeat (3) @(posedge ref_clk);
    tube_moving <= 1'b1;
    @(posedge ref_clk);
    tube_moving <= 1'b0;
    note(3, 10'h010);
    frame(1'b0, 16'h0100, p0, 8'h10);
    note(4, 10'h000);
    msg_timeout_evt <= 1'b1;
    @(posedge ref_clk);
    msg_timeout_evt <= 1'b0;
    note(3, 10'h020);
    $display("event test done");
    note(100, 10'h120);
    frame(1'b1, 16'h0100, p0, 8'h10);
    note(4, 10'h120);
    safe_state_msg <= 1'b1;
    @(posedge ref_clk);
    safe_state_msg <= 1'b0;
    note(2, 10'h020);
    frame(1'b1, 16'h0100, p0, 8'h10);
    note(4, 10'h200);
    $display("sleep test done");
    // Frozen enable holds every monitor flop, so the disable frame is lost
    clk_en <= 1'b0;
    frame(1'b0, 16'h0100, p0, 8'h10);
    note(4, 10'h200);
    clk_en <= 1'b1;
    note(4, 10'h200);
    frame(1'b0, 16'h0100, p0, 8'h10);
    note(4, 10'h000);
    $display("enable test done");
    @(posedge ref_clk);
    end_of_test();
  end
endmodule : aff_monitor_tb
